// >>> aff_pkg.sv
`default_nettype none

package aff_pkg;

  // ****************************************************************
  // Frame layout, positions counted from 1.
  // ****************************************************************
  localparam int POS_W = 13;
  localparam logic [12:0] FRAME_BITS = 13'h1083;
  localparam logic [12:0] SYNC_LAST = 13'h000E;
  localparam logic [12:0] PRE_FIRST = 13'h000F;
  localparam logic [12:0] PRE_LAST = 13'h0F86;
  localparam logic [12:0] ENC_FIRST = 13'h0F87;
  localparam logic [12:0] ENC_LAST = 13'h0FB0;
  localparam logic [12:0] VEND_FIRST = 13'h0FB1;
  localparam logic [12:0] VEND_LAST = 13'h1030;
  localparam logic [12:0] PAIR_FIRST = 13'h1031;
  localparam logic [12:0] PAIR_LAST = 13'h1032;
  localparam logic [12:0] RSV_FIRST = 13'h1033;
  localparam logic [12:0] RSV_LAST = 13'h1073;
  localparam logic [12:0] CRC_FIRST = 13'h1074;

  // ****************************************************************
  // Field contents.
  // ****************************************************************
  localparam int SYNC_W = 14;
  localparam logic [13:0] SYNC_TRAIN = 14'h3E6B;
  localparam logic [13:0] SYNC_FINAL = 14'h359F;
  localparam int COEF_W = 22;
  localparam logic [4:0] COEF_LAST_BIT = 5'h15;
  localparam int NCOEF_MAX = 180;
  localparam logic [7:0] NCOEF_MAX_V = 8'hB4;
  localparam logic [7:0] NCOEF_MIN_V = 8'h80;
  localparam int ENC_W = 21;
  localparam int VEND_W = 128;
  localparam int CRC_W = 16;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // ****************************************************************
  // Scrambler and buffering.
  // ****************************************************************
  localparam int SCR_W = 23;
  localparam int TAP_CUST = 18;
  localparam int TAP_LINE = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int LANE_W = 2;

  // ****************************************************************
  // Modes and clock references.
  // ****************************************************************
  typedef enum logic [1:0] {
    TX_OFF,
    TX_TRAIN,
    TX_FINAL
  } aff_tx_t;

  typedef enum logic [1:0] {
    REF_LOCAL,
    REF_NET,
    REF_TX_DATA,
    REF_RX_SYMBOL
  } aff_ref_t;

endpackage : aff_pkg

`default_nettype wire

// >>> aff_stream_if.sv
`default_nettype none

interface aff_stream_if #(
  parameter int W = 2
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );

  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface : aff_stream_if

`default_nettype wire

// >>> aff_fifo.sv
`default_nettype none

module aff_fifo #(
  parameter int W = 2,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  aff_stream_if.snk in_s,
  aff_stream_if.src out_s
);
  import aff_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } aff_fifo_st_t;

  aff_fifo_st_t s_r;
  aff_fifo_st_t s_nxt;
  logic push;
  logic pop;

  // Full and empty come straight from the count, so a stalled drain
  // side makes the filling side wait.
  assign in_s.ready = (s_r.cnt != (AW + 1)'(DEPTH));
  assign out_s.valid = (s_r.cnt != '0);
  assign out_s.data = s_r.mem[s_r.rp];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_s.data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // aff_fifo

`default_nettype wire

// >>> aff_framer.sv
// Contract
// - Frame is 4227 bits, bit 1 first, repeating.
// - Repeat frame unchanged while training signals run.
// - Sync bits 1-14 bypass the scrambler.
// - Training sync is 11111001101011, leftmost first.
// - Final-signal sync is the reversed pattern.
// - Precoder coefficient: 22-bit signed, LSB first.
// - Coefficients ascending from bit 15 to 3974.
// - Between 128 and 180 coefficients supported.
// - Unused coefficient slots sent as zeros.
// - Encoder A bits 3975-3995, B 3996-4016.
// - Encoder order a0 first through b20 last.
// - Bits 4017-4144 carry constant vendor data.
// - Line side sends pair count minus one.
// - Customer side sends each pair's ordinal.
// - Pair bits zero outside multi-pair or four-wire (code also sends zeros in four-wire).
// - Reserved bits 4147-4211 sent as zeros.
// - CRC covers bits 15-4211, bit 15 highest.
// - CRC-16 D16+D12+D5+1 at bits 4212-4227.
// - Each pair runs its own independent framer.
// - Customer side locks to received symbol clock.
// - Synchronous line side: data or network reference.
// - Network reference is a multiple of 8 kHz.
// - Non-sync bits through the 23rd-order scrambler.
`default_nettype none

module aff_framer #(
  parameter int NCOEF = aff_pkg::NCOEF_MAX,
  parameter int DEPTH = aff_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire aff_pkg::aff_tx_t tx_sel,
  input wire logic network_termination_unit,
  input wire logic mpair_en,
  input wire logic four_wire,
  input wire logic [1:0] pair_cnt_m1,
  input wire logic [1:0] pair_ordinal,
  input wire logic [7:0] ncoef,
  input wire logic coef_wr,
  input wire logic [7:0] coef_idx,
  input wire logic [aff_pkg::COEF_W-1:0] coef_data,
  input wire logic [aff_pkg::ENC_W-1:0] enc_a,
  input wire logic [aff_pkg::ENC_W-1:0] enc_b,
  input wire logic [aff_pkg::VEND_W-1:0] vendor_data,
  input wire logic sync_mode,
  input wire logic use_net_ref,
  input wire logic [15:0] net_ref_khz,
  input wire logic line_ready,
  output logic line_bit,
  output logic line_sync,
  output logic line_valid,
  output logic running,
  output logic frame_start,
  output aff_pkg::aff_ref_t clk_ref_sel,
  output logic txdata_lock_req,
  output logic net_ref_err
);
  import aff_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } aff_st_t;

  typedef struct packed {
    aff_st_t st;
    logic [POS_W-1:0] pos;
    logic [7:0] cidx;
    logic [4:0] cbit;
    logic fin;
    logic [CRC_W-1:0] crc;
    logic [NCOEF-1:0][COEF_W-1:0] coef;
    logic [7:0] ncoef;
    logic [2*ENC_W-1:0] enc;
    logic [VEND_W-1:0] vend;
    logic [1:0] pair;
    logic [SCR_W-1:0] scr;
    logic ob;
    logic osync;
    logic ov;
    logic fstart;
    aff_ref_t ref_sel;
    logic lock_req;
    logic ref_err;
  } aff_framer_st_t;

  aff_framer_st_t s_r;
  aff_framer_st_t s_nxt;

  aff_stream_if #(.W(LANE_W)) fr_if ();
  aff_stream_if #(.W(LANE_W)) sc_if ();

  logic gen_bit;
  logic gen_sync;
  logic fb;
  logic [SYNC_W-1:0] sync_pat;
  logic [7:0] ncoef_cl;
  logic sb;
  logic tap;

  // ****************************************************************
  // Frame buffer between the bit generator and the scrambler.
  // ****************************************************************
  // The buffer lets the generator run ahead while the mapper stalls;
  // the generator only advances when the buffer accepts a bit.
  aff_fifo #(
    .W(LANE_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_s(fr_if.snk),
    .out_s(sc_if.src)
  );

  assign fr_if.valid = (s_r.st == ST_RUN);
  assign fr_if.data = {gen_sync, gen_bit};
  assign sc_if.ready = !s_r.ov || line_ready;

  assign line_bit = s_r.ob;
  assign line_sync = s_r.osync;
  assign line_valid = s_r.ov;
  assign running = (s_r.st == ST_RUN);
  assign frame_start = s_r.fstart;
  assign clk_ref_sel = s_r.ref_sel;
  assign txdata_lock_req = s_r.lock_req;
  assign net_ref_err = s_r.ref_err;

  // ****************************************************************
  // Bit selection for the current frame position.
  // ****************************************************************
  always_comb begin
    sync_pat = s_r.fin ? SYNC_FINAL : SYNC_TRAIN;
    gen_bit = 1'b0;
    gen_sync = 1'b0;
    if (s_r.pos <= SYNC_LAST) begin
      // Leftmost pattern bit sits at the top and goes out first.
      gen_bit = sync_pat[4'(SYNC_LAST - s_r.pos)];
      gen_sync = 1'b1;
    end else if (s_r.pos <= PRE_LAST) begin
      if (s_r.cidx < s_r.ncoef) begin
        gen_bit = s_r.coef[s_r.cidx][s_r.cbit];
      end else begin
        gen_bit = 1'b0;
      end
    end else if (s_r.pos <= ENC_LAST) begin
      gen_bit = s_r.enc[6'(s_r.pos - ENC_FIRST)];
    end else if (s_r.pos <= VEND_LAST) begin
      gen_bit = s_r.vend[7'(s_r.pos - VEND_FIRST)];
    end else if (s_r.pos <= PAIR_LAST) begin
      gen_bit = s_r.pair[s_r.pos == PAIR_LAST];
    end else if (s_r.pos <= RSV_LAST) begin
      gen_bit = 1'b0;
    end else begin
      gen_bit = s_r.crc[CRC_W-1];
    end
  end

  // Out-of-range counts are clamped so the frame length never moves.
  always_comb begin
    if (ncoef < NCOEF_MIN_V) begin
      ncoef_cl = NCOEF_MIN_V;
    end else if (ncoef > NCOEF_MAX_V) begin
      ncoef_cl = NCOEF_MAX_V;
    end else begin
      ncoef_cl = ncoef;
    end
  end

  assign fb = s_r.crc[CRC_W-1] ^ gen_bit;
  assign tap = network_termination_unit ?
    s_r.scr[TAP_CUST-1] : s_r.scr[TAP_LINE-1];
  assign sb = sc_if.data[0] ^ tap ^ s_r.scr[SCR_W-1];

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.fstart = 1'b0;

    // Clock reference choice.
    if (network_termination_unit) begin
      s_nxt.ref_sel = REF_RX_SYMBOL;
    end else if (use_net_ref) begin
      s_nxt.ref_sel = REF_NET;
    end else if (sync_mode) begin
      s_nxt.ref_sel = REF_TX_DATA;
    end else begin
      s_nxt.ref_sel = REF_LOCAL;
    end
    s_nxt.lock_req = !network_termination_unit && sync_mode &&
      use_net_ref;
    s_nxt.ref_err = use_net_ref &&
      ((net_ref_khz[2:0] != 3'h0) || (net_ref_khz == 16'h0000));

    case (s_r.st)
      ST_IDLE: begin
        // Coefficients may only be loaded while no frame is running.
        if (coef_wr && (coef_idx < 8'(NCOEF))) begin
          s_nxt.coef[coef_idx] = coef_data;
        end
        if (tx_sel != TX_OFF) begin
          s_nxt.st = ST_RUN;
          s_nxt.pos = POS_W'(1);
          s_nxt.cidx = '0;
          s_nxt.cbit = '0;
          s_nxt.crc = CRC_INIT;
          s_nxt.fin = (tx_sel == TX_FINAL);
          s_nxt.fstart = 1'b1;
          // Snapshot holds frame contents fixed for the whole signal.
          s_nxt.ncoef = ncoef_cl;
          s_nxt.enc = {enc_b, enc_a};
          s_nxt.vend = vendor_data;
          if (!mpair_en || four_wire) begin
            s_nxt.pair = 2'h0;
          end else if (network_termination_unit) begin
            s_nxt.pair = pair_ordinal;
          end else begin
            s_nxt.pair = pair_cnt_m1;
          end
        end
      end
      ST_RUN: begin
        if (fr_if.ready) begin
          // CRC over bits 15..4211, first bit at highest degree.
          if ((s_r.pos >= PRE_FIRST) && (s_r.pos <= RSV_LAST)) begin
            s_nxt.crc = {s_r.crc[CRC_W-2:0], 1'b0} ^
              (fb ? CRC_POLY : CRC_INIT);
          end else if (s_r.pos >= CRC_FIRST) begin
            s_nxt.crc = {s_r.crc[CRC_W-2:0], 1'b0};
          end
          if ((s_r.pos >= PRE_FIRST) && (s_r.pos <= PRE_LAST)) begin
            if (s_r.cbit == COEF_LAST_BIT) begin
              s_nxt.cbit = '0;
              s_nxt.cidx = s_r.cidx + 1'b1;
            end else begin
              s_nxt.cbit = s_r.cbit + 1'b1;
            end
          end
          if (s_r.pos == FRAME_BITS) begin
            s_nxt.pos = POS_W'(1);
            s_nxt.cidx = '0;
            s_nxt.cbit = '0;
            s_nxt.crc = CRC_INIT;
            s_nxt.fin = (tx_sel == TX_FINAL);
            // Stopping only at a frame boundary keeps every frame whole.
            if (tx_sel == TX_OFF) begin
              s_nxt.st = ST_IDLE;
            end else begin
              s_nxt.fstart = 1'b1;
            end
          end else begin
            s_nxt.pos = s_r.pos + 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Scrambler and output stage.
    if (sc_if.ready) begin
      if (sc_if.valid) begin
        s_nxt.ov = 1'b1;
        s_nxt.osync = sc_if.data[1];
        if (sc_if.data[1]) begin
          // Sync bits leave the scrambler register untouched.
          s_nxt.ob = sc_if.data[0];
        end else begin
          s_nxt.ob = sb;
          s_nxt.scr = {s_r.scr[SCR_W-2:0], sb};
        end
      end else begin
        s_nxt.ov = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // aff_framer

`default_nettype wire

// >>> aff_framer_properties.sv
`default_nettype none

module aff_framer_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic network_termination_unit,
  input wire logic sync_mode,
  input wire logic use_net_ref,
  input wire logic [15:0] net_ref_khz,
  input wire logic line_ready,
  input wire logic line_bit,
  input wire logic line_sync,
  input wire logic line_valid,
  input wire logic running,
  input wire logic frame_start,
  input wire aff_pkg::aff_ref_t clk_ref_sel,
  input wire logic txdata_lock_req,
  input wire logic net_ref_err
);
  timeunit 1ns;
  timeprecision 100ps;
  import aff_pkg::*;

  // ****************************************************************
  // Line stream and clock reference properties.
  // ****************************************************************
  logic [4:0] sync_run_r;
  logic acc;
  logic bad_ref;

  assign acc = line_valid && line_ready;
  // A zero frequency is no multiple at all, so it counts as bad too.
  assign bad_ref = net_ref_khz[2:0] != 3'h0 || net_ref_khz == 16'h0000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_run_r <= 5'h00;
    end else if (acc) begin
      sync_run_r <= line_sync ? sync_run_r + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  stall_hold_a: assert property (
    line_valid && !line_ready |=>
      line_valid && $stable(line_bit) && $stable(line_sync))
    else $error("Line output moved while stalled.");
  sync_len_a: assert property (
    acc && !line_sync && sync_run_r != 5'h00 |-> sync_run_r == 5'h0E)
    else $error("Sync run is not fourteen bits.");
  start_pulse_a: assert property (
    frame_start |=> !frame_start)
    else $error("Frame start longer than one cycle.");
  run_start_a: assert property (
    $rose(running) |-> frame_start)
    else $error("Run began without frame start.");
  ref_cust_a: assert property (
    network_termination_unit |=> clk_ref_sel == REF_RX_SYMBOL)
    else $error("Customer side not on received clock.");
  ref_net_a: assert property (
    !network_termination_unit && use_net_ref |=> clk_ref_sel == REF_NET)
    else $error("Line side not on network reference.");
  ref_txd_a: assert property (
    !network_termination_unit && !use_net_ref && sync_mode |=>
      clk_ref_sel == REF_TX_DATA)
    else $error("Line side not on data clock.");
  lock_req_a: assert property (
    !network_termination_unit && sync_mode && use_net_ref |=>
      txdata_lock_req)
    else $error("Data clock lock not requested.");
  net_err_a: assert property (
    use_net_ref && bad_ref |=> net_ref_err)
    else $error("Bad reference frequency not flagged.");
  net_ok_a: assert property (
    !use_net_ref || !bad_ref |=> !net_ref_err)
    else $error("Good reference frequency flagged.");
endmodule // aff_framer_chk

bind aff_framer aff_framer_chk aff_framer_chk_i (.*);

`default_nettype wire

// >>> aff_far_end.sv
`default_nettype none

module aff_far_end (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic network_termination_unit,
  input wire logic stall,
  input wire logic line_bit,
  input wire logic line_sync,
  input wire logic line_valid,
  output logic line_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Far-end mapper and descrambler.
  // ****************************************************************
  logic [22:0] hist_r;
  logic [1:0] pace_r;
  logic last_sync_r;
  int pos_r;
  int nfr;
  int pos;
  logic fr [1:4227];
  logic sf [1:4227];

  // Stalled, it takes one bit in four, so the framer buffer fills up.
  assign line_ready = !(stall && pace_r != 2'h0);
  assign pos = (line_sync && !last_sync_r) ? 1 : pos_r + 1;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hist_r <= 23'h00_0000;
      pace_r <= 2'h0;
      last_sync_r <= 1'b0;
      pos_r <= 0;
      nfr <= 0;
    end else begin
      pace_r <= pace_r + 2'h1;
      if (line_valid && line_ready) begin
        last_sync_r <= line_sync;
        pos_r <= pos;
        sf[pos] <= line_sync;
        if (line_sync) begin
          fr[pos] <= line_bit;
        end else begin
          fr[pos] <= line_bit ^ hist_r[22]
            ^ (network_termination_unit ? hist_r[17] : hist_r[4]);
          hist_r <= {hist_r[21:0], line_bit};
        end
        if (pos == 4227) begin
          nfr <= nfr + 1;
        end
      end
    end
  end
endmodule // aff_far_end

`default_nettype wire

// >>> aff_framer_bench.sv
`default_nettype none

module aff_framer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import aff_pkg::*;

  // ****************************************************************
  // Stimulus, capture and checks.
  // ****************************************************************
  logic mclk = 1'b0, rst_n = 1'b0, mpair_en = 1'b0;
  logic network_termination_unit = 1'b0;
  logic four_wire = 1'b0, coef_wr = 1'b0, sync_mode = 1'b0;
  logic use_net_ref = 1'b0, stall = 1'b0;
  aff_tx_t tx_sel = TX_OFF;
  logic [1:0] pair_cnt_m1 = 2'h0, pair_ordinal = 2'h0;
  logic [7:0] ncoef = 8'h00, coef_idx = 8'h00;
  logic [21:0] coef_data = 22'h00_0000;
  logic [20:0] enc_a = 21'h1A_5C3E, enc_b = 21'h0E_3B71;
  logic [127:0] vendor_data = 128'hC3A5_9F01_7E24_D8B6_5A0F_3C96_E17B_4D28;
  logic [15:0] net_ref_khz = 16'h0000;
  logic line_ready, line_bit, line_sync, line_valid, running;
  logic frame_start, txdata_lock_req, net_ref_err;
  aff_ref_t clk_ref_sel;
  logic [21:0] cf [180];
  logic ex [1:4227];
  int fail_count = 0, comparisons = 0, cycles = 0;

  aff_framer aff_framer_i (.*);
  aff_far_end aff_far_end_i (.*);

  initial forever #12.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic setup(input logic cs, mp, fw, input logic [1:0] cn, od,
                       input logic st);
    @(posedge mclk);
    network_termination_unit <= cs;
    mpair_en <= mp;
    four_wire <= fw;
    pair_cnt_m1 <= cn;
    pair_ordinal <= od;
    stall <= st;
  endtask

  task automatic build_exp(input logic fin, input int nco,
                           input logic [1:0] pf);
    logic [13:0] sw;
    logic [15:0] r;
    sw = 14'h3E6B;
    for (int i = 1; i <= 4227; i++) ex[i] = 1'b0;
    for (int i = 1; i <= 14; i++) ex[i] = fin ? sw[i - 1] : sw[14 - i];
    for (int k = 0; k < nco; k++)
      for (int j = 0; j < 22; j++) ex[15 + 22 * k + j] = cf[k][j];
    for (int j = 0; j < 21; j++) begin
      ex[3975 + j] = enc_a[j];
      ex[3996 + j] = enc_b[j];
    end
    for (int j = 0; j < 128; j++) ex[4017 + j] = vendor_data[j];
    ex[4145] = pf[0];
    ex[4146] = pf[1];
    r = 16'h0000;
    for (int i = 15; i <= 4211; i++)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ ex[i]) ? 16'h1021 : 16'h0000);
    for (int j = 0; j < 16; j++) ex[4212 + j] = r[15 - j];
  endtask

  task automatic wait_frame(input int n);
    int c;
    c = 0;
    while (aff_far_end_i.nfr < n && c < 40000) begin
      @(negedge mclk);
      c++;
    end
    check(aff_far_end_i.nfr, n);
    for (int i = 1; i <= 4227; i++) begin
      check(aff_far_end_i.fr[i], ex[i]);
      check(aff_far_end_i.sf[i], i <= 14);
    end
  endtask

  // Reset drops the request first, so no run starts while loading.
  task automatic run(input aff_tx_t sel, input logic [7:0] nc,
                     input int nco, input logic [1:0] pf);
    rst_n <= 1'b0;
    tx_sel <= TX_OFF;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int k = 0; k < 180; k++) begin
      cf[k] = 22'(k * 22'h0_1D37 + 22'h2_A5C1);
      coef_wr <= 1'b1;
      coef_idx <= 8'(k);
      coef_data <= cf[k];
      @(posedge mclk);
    end
    coef_wr <= 1'b0;
    ncoef <= nc;
    tx_sel <= sel;
    build_exp(sel == TX_FINAL, nco, pf);
    wait_frame(1);
  endtask

  task automatic sc_clock_ref();
    logic [15:0] k;
    logic [2:0] m;
    for (int i = 0; i < 24; i++) begin
      m = 3'(i);
      k = (i < 8) ? 16'h0800 : (i < 16) ? 16'h0607 : 16'h0000;
      @(posedge mclk);
      network_termination_unit <= m[2];
      use_net_ref <= m[1];
      sync_mode <= m[0];
      net_ref_khz <= k;
      @(posedge mclk);
      @(negedge mclk);
      check(clk_ref_sel, m[2] ? 2'h3 : m[1] ? 2'h1 : m[0] ? 2'h2 : 2'h0);
      check(txdata_lock_req, !m[2] && m[1] && m[0]);
      check(net_ref_err, m[1] && (k[2:0] != 3'h0 || k == 16'h0000));
    end
  endtask

  task automatic sc_train_line();
    setup(1'b0, 1'b1, 1'b0, 2'h2, 2'h1, 1'b1);
    run(TX_TRAIN, 8'hB4, 180, 2'h2);
    @(posedge mclk);
    enc_a <= ~enc_a;
    tx_sel <= TX_OFF;
    wait_frame(2);
    repeat (40) @(posedge mclk);
    @(negedge mclk);
    check(running, 1'b0);
    check(line_valid, 1'b0);
    check(aff_far_end_i.nfr, 2);
  endtask

  task automatic sc_final_cust();
    setup(1'b1, 1'b1, 1'b0, 2'h1, 2'h3, 1'b0);
    run(TX_FINAL, 8'h80, 128, 2'h3);
  endtask

  task automatic sc_four_wire();
    setup(1'b0, 1'b1, 1'b1, 2'h3, 2'h2, 1'b0);
    run(TX_TRAIN, 8'hC8, 180, 2'h0);
  endtask

  initial begin
    setup(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0);
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    sc_clock_ref();
    sc_train_line();
    sc_final_cust();
    sc_four_wire();
    tally_and_finish();
  end
endmodule // aff_framer_bench

`default_nettype wire
